//--- design/sftc_ctrl.sv
// Transmit FIFO request, transmit hold and transfer interrupt control
`timescale 1ns/1ps
module sftc_ctrl
  import sftc_pkg::*;
#(
  parameter int CNT_W = 4     // Width of FIFO count and threshold
) (
  input wire logic clk_i,                // System clock, 40 MHz
  input wire logic rst_i,                // Synchronous reset
  // Classic Wishbone slave
  input wire logic wb_cyc_i,             // Bus cycle
  input wire logic wb_stb_i,             // Strobe
  input wire logic wb_we_i,              // Write enable
  input wire logic [11:0] wb_adr_i,      // Byte address
  input wire logic [3:0] wb_sel_i,       // Byte lanes
  input wire logic [31:0] wb_dat_i,      // Write data
  output logic [31:0] wb_dat_o,          // Read data
  output logic wb_ack_o,                 // Acknowledge
  // FIFO and shift engine side
  input wire logic [CNT_W-1:0] tx_fifo_count_i,     // Bytes held
  input wire logic [CNT_W-1:0] tx_fifo_threshold_i, // Threshold
  input wire logic [7:0] tx_fifo_data_i, // FIFO head byte
  output logic tx_fifo_pop_o,            // Pop one byte, pulse
  input wire logic shift_busy_i,         // Byte on the wire
  input wire logic shift_start_i,        // New transfer, pulse
  output logic [7:0] shift_byte_o,       // Byte for new transfer
  input wire logic sdo_i,                // Engine data out
  output logic sdo_o,                    // Data out pin level
  input wire logic transfer_complete_flag_i, // Transfer done flag
  // Status and interrupts
  output logic tx_fifo_request_o,        // Request flag level
  output logic tx_held_o,                // Transmit path stalled
  output logic serial_irq_o,             // Serial port interrupt
  output logic irq_o                     // Event interrupt
);

  import sftc_pkg::*;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------

  // Word index of a byte address
  function automatic logic [9:0] sftc_index(input logic [11:0] adr);
    sftc_index = adr[11:2];
  endfunction

  // True when the access hits the given register
  function automatic logic sftc_hit(input logic [11:0] adr,
                                    input logic [9:0] idx);
    sftc_hit = (sftc_index(adr) == idx);
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_stb;
  logic rd_stb;

  assign req = wb_cyc_i && wb_stb_i;

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Accesses take effect on the acknowledge edge only
  assign wr_stb = req && ack_q && wb_we_i;
  assign rd_stb = req && ack_q && !wb_we_i;
  assign wb_ack_o = ack_q;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  logic hold_lvl_q;
  logic stall_q;
  logic xfer_ie_q;
  logic [SFTC_EV_W-1:0] mask_q;
  logic ctrl_wr;
  logic mask_wr;

  assign ctrl_wr = wr_stb && wb_sel_i[0] &&
                   sftc_hit(wb_adr_i, SFTC_IDX_TX_CTRL);
  assign mask_wr = wr_stb && wb_sel_i[0] &&
                   sftc_hit(wb_adr_i, SFTC_IDX_IRQ_MASK);

  // Writable bits of the control register; bit 7 ignores writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_lvl_q <= SFTC_RST_HOLD_LVL;
      stall_q <= SFTC_RST_STALL;
      xfer_ie_q <= SFTC_RST_XFER_IE;
    end else if (ctrl_wr) begin
      hold_lvl_q <= wb_dat_i[SFTC_BIT_HOLD_LVL];
      stall_q <= wb_dat_i[SFTC_BIT_STALL];
      xfer_ie_q <= wb_dat_i[SFTC_BIT_XFER_IE];
    end
  end

  // Event mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= SFTC_RST_IRQ_MASK;
    end else if (mask_wr) begin
      mask_q <= wb_dat_i[SFTC_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit request flag
  // ----------------------------------------------------------------
  logic req_flag_q;
  logic req_flag_d;

  // Compared every cycle so FIFO traffic and threshold edits both count
  assign req_flag_d = (tx_fifo_count_i <= tx_fifo_threshold_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_flag_q <= SFTC_RST_TX_REQ;
    end else begin
      req_flag_q <= req_flag_d;
    end
  end

  assign tx_fifo_request_o = req_flag_q;

  // ----------------------------------------------------------------
  // Transfer-complete interrupt gating
  // ----------------------------------------------------------------
  logic serial_irq_q;

  // Level follows the flag while enabled, silent while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_irq_q <= 1'b0;
    end else begin
      serial_irq_q <= transfer_complete_flag_i && xfer_ie_q;
    end
  end

  assign serial_irq_o = serial_irq_q;

  // ----------------------------------------------------------------
  // Sticky events, cleared by reading the status register
  // ----------------------------------------------------------------
  logic xfer_flag_prev_q;
  logic req_prev_q;
  logic [SFTC_EV_W-1:0] ev_set;
  logic [SFTC_EV_W-1:0] stat_q;
  logic stat_rd;
  logic irq_q;

  // Previous levels for rising-edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_flag_prev_q <= 1'b0;
      req_prev_q <= SFTC_RST_TX_REQ;
    end else begin
      xfer_flag_prev_q <= transfer_complete_flag_i;
      req_prev_q <= req_flag_q;
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[SFTC_EV_XFER_DONE] = transfer_complete_flag_i &&
                                !xfer_flag_prev_q;
    ev_set[SFTC_EV_TX_REQ] = req_flag_q && !req_prev_q;
  end

  assign stat_rd = rd_stb && sftc_hit(wb_adr_i, SFTC_IDX_IRQ_STAT);

  // Only bits returned by the read are cleared; the read data was
  // captured a cycle earlier, so an event in between must survive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else if (stat_rd) begin
      stat_q <= (stat_q & ~rd_q[SFTC_EV_W-1:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  // Registered level so glitches from decode never reach the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Transmit hold unit
  // ----------------------------------------------------------------
  sftc_hold_if hold_if ();

  assign hold_if.stall = stall_q;
  assign hold_if.level_sel = hold_lvl_q;
  assign hold_if.busy = shift_busy_i;
  assign hold_if.start = shift_start_i;
  assign hold_if.fifo_empty = (tx_fifo_count_i == '0);
  assign hold_if.fifo_data = tx_fifo_data_i;
  assign hold_if.sdo_in = sdo_i;

  // Byte choice, pop and pin forcing live in the hold unit
  sftc_hold u_hold (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .hold (hold_if.unit)
  );

  assign tx_fifo_pop_o = hold_if.pop;
  assign shift_byte_o = hold_if.tx_byte;
  assign sdo_o = hold_if.sdo_out;
  assign tx_held_o = hold_if.held;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  // Unmapped words read as zero; bits 3..0 belong to the receive side
  always_comb begin
    rd_d = '0;
    unique case (sftc_index(wb_adr_i))
      SFTC_IDX_TX_CTRL: begin
        rd_d[SFTC_BIT_TX_REQ] = req_flag_q;
        rd_d[SFTC_BIT_HOLD_LVL] = hold_lvl_q;
        rd_d[SFTC_BIT_STALL] = stall_q;
        rd_d[SFTC_BIT_XFER_IE] = xfer_ie_q;
      end
      SFTC_IDX_IRQ_STAT: rd_d[SFTC_EV_W-1:0] = stat_q;
      SFTC_IDX_IRQ_MASK: rd_d[SFTC_EV_W-1:0] = mask_q;
      default: rd_d = '0;
    endcase
  end

  // Data captured with the wait state, valid with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (req && !ack_q && !wb_we_i) begin
      rd_q <= rd_d;
    end
  end

  assign wb_dat_o = rd_q;

endmodule

//--- design/sftc_hold.sv
// Transmit hold unit: byte selection, FIFO pop and data-out forcing
`timescale 1ns/1ps
module sftc_hold
  import sftc_pkg::*;
(
  input wire logic clk_i,     // System clock
  input wire logic rst_i,     // Synchronous reset, active high
  sftc_hold_if.unit hold      // Link to the register side
);

  // ----------------------------------------------------------------
  // Hold sequencing
  // ----------------------------------------------------------------
  sftc_hold_t state_q;
  logic [7:0] byte_q;
  logic pop_q;
  logic sdo_q;

  // Stall waits for the byte on the wire to finish first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SFTC_RUN;
    end else begin
      unique case (state_q)
        SFTC_RUN: begin
          if (hold.stall) begin
            state_q <= hold.busy ? SFTC_DRAIN : SFTC_HELD;
          end
        end
        SFTC_DRAIN: begin
          if (!hold.stall) begin
            state_q <= SFTC_RUN;
          end else if (!hold.busy) begin
            state_q <= SFTC_HELD;
          end
        end
        SFTC_HELD: begin
          if (!hold.stall) begin
            state_q <= SFTC_RUN;
          end
        end
        default: state_q <= SFTC_RUN;
      endcase
    end
  end

  // Byte for a new transfer: fill byte when stalled or FIFO empty, else FIFO head
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_q <= SFTC_FILL_BYTE;
      pop_q <= 1'b0;
    end else begin
      pop_q <= 1'b0;
      if (hold.start) begin
        if (hold.stall || hold.fifo_empty) begin
          byte_q <= SFTC_FILL_BYTE;
        end else begin
          byte_q <= hold.fifo_data;
          pop_q <= 1'b1;
        end
      end
    end
  end

  // Data out forced only once the running byte has gone out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q <= SFTC_RST_HOLD_LVL;
    end else if (state_q == SFTC_HELD && !hold.busy) begin
      sdo_q <= hold.level_sel;
    end else begin
      sdo_q <= hold.sdo_in;
    end
  end

  assign hold.tx_byte = byte_q;
  assign hold.pop = pop_q;
  assign hold.sdo_out = sdo_q;
  assign hold.held = (state_q == SFTC_HELD);

endmodule

//--- design/sftc_hold_if.sv
// Signals between the register side and the transmit hold unit
`timescale 1ns/1ps
interface sftc_hold_if;
  logic stall;
  logic level_sel;
  logic busy;
  logic start;
  logic fifo_empty;
  logic [7:0] fifo_data;
  logic pop;
  logic [7:0] tx_byte;
  logic sdo_in;
  logic sdo_out;
  logic held;

  // Register side: owns control bits and the pins
  modport ctrl (
    output stall, level_sel, busy, start, fifo_empty, fifo_data, sdo_in,
    input pop, tx_byte, sdo_out, held
  );

  // Hold unit side
  modport unit (
    input stall, level_sel, busy, start, fifo_empty, fifo_data, sdo_in,
    output pop, tx_byte, sdo_out, held
  );
endinterface

//--- design/sftc_pkg.sv
// Constants shared by the transmit hold and request control block
package sftc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] SFTC_IDX_TX_CTRL = 10'h09b;
  localparam logic [9:0] SFTC_IDX_IRQ_STAT = 10'h0a0;
  localparam logic [9:0] SFTC_IDX_IRQ_MASK = 10'h0a1;

  // ----------------------------------------------------------------
  // Field positions of fifo_tx_control
  // ----------------------------------------------------------------
  localparam int SFTC_BIT_TX_REQ = 7;
  localparam int SFTC_BIT_HOLD_LVL = 6;
  localparam int SFTC_BIT_STALL = 5;
  localparam int SFTC_BIT_XFER_IE = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic SFTC_RST_TX_REQ = 1'b1;
  localparam logic SFTC_RST_HOLD_LVL = 1'b1;
  localparam logic SFTC_RST_STALL = 1'b0;
  localparam logic SFTC_RST_XFER_IE = 1'b1;
  localparam logic [1:0] SFTC_RST_IRQ_MASK = 2'h0;

  // ----------------------------------------------------------------
  // Event status bit positions and the byte sent while stalled
  // ----------------------------------------------------------------
  localparam int SFTC_EV_XFER_DONE = 0;
  localparam int SFTC_EV_TX_REQ = 1;
  localparam int SFTC_EV_W = 2;
  localparam logic [7:0] SFTC_FILL_BYTE = 8'hff;

  // Hold state of the transmit path
  typedef enum logic [1:0] {
    SFTC_RUN,
    SFTC_DRAIN,
    SFTC_HELD
  } sftc_hold_t;

endpackage

//--- test/sftc_ctrl_chk.sv
// Port assertions for the transmit hold and request control block
`timescale 1ns/1ps
module sftc_ctrl_chk #(
  parameter int CNT_W = 4          // Count width
) (
  input wire logic clk_i,          // Clock
  input wire logic rst_i,          // Reset
  input wire logic wb_cyc_i,       // Cycle
  input wire logic wb_stb_i,       // Strobe
  input wire logic wb_we_i,        // Write
  input wire logic [11:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic wb_ack_o,       // Ack
  input wire logic [CNT_W-1:0] tx_fifo_count_i, // Fill
  input wire logic [CNT_W-1:0] tx_fifo_threshold_i, // Threshold
  input wire logic [7:0] tx_fifo_data_i, // Head
  input wire logic tx_fifo_pop_o,  // Pop
  input wire logic shift_busy_i,   // Busy
  input wire logic shift_start_i,  // Start
  input wire logic [7:0] shift_byte_o, // Byte
  input wire logic sdo_o,          // Pin
  input wire logic transfer_complete_flag_i, // Done flag
  input wire logic tx_fifo_request_o, // Request
  input wire logic tx_held_o,      // Held
  input wire logic serial_irq_o    // Serial irq
);
  logic [6:4] ctl_q;
  // Mirror of writable control bits; taken at the acknowledge edge
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ctl_q <= 3'h5;
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i == 12'h26c)
      ctl_q <= wb_dat_i[6:4];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_held_idle;
    tx_held_o && !shift_busy_i;
  endsequence
  AST_REQ: assert property (!$past(rst_i) |-> tx_fifo_request_o ==
    ($past(tx_fifo_count_i) <= $past(tx_fifo_threshold_i)))
    else $error("request flag wrong");
  AST_SIRQ_OFF: assert property (!$past(rst_i) && !$past(ctl_q[4])
    |-> !serial_irq_o) else $error("serial irq while disabled");
  AST_SIRQ_ON: assert property (!$past(rst_i) && $past(ctl_q[4]) &&
    $past(transfer_complete_flag_i) |-> serial_irq_o)
    else $error("serial irq missing");
  AST_FILL: assert property (shift_start_i && ctl_q[5] |=>
    shift_byte_o == 8'hff && !tx_fifo_pop_o) else $error("held byte wrong");
  AST_POP: assert property (shift_start_i && !ctl_q[5] &&
    tx_fifo_count_i != '0 |=> tx_fifo_pop_o &&
    shift_byte_o == $past(tx_fifo_data_i)) else $error("fifo byte wrong");
  AST_POP_CAUSE: assert property (tx_fifo_pop_o |->
    $past(shift_start_i)) else $error("pop without transfer");
  AST_DRAIN: assert property ($rose(tx_held_o) |->
    !$past(shift_busy_i) && $past(ctl_q[5])) else $error("held too early");
  AST_LEVEL: assert property (s_held_idle |=>
    sdo_o == $past(ctl_q[6])) else $error("held level wrong");
endmodule

//--- test/sftc_ctrl_test.sv
// Self-checking bench for the transmit hold and request control block
`timescale 1ns/1ps
module sftc_ctrl_test;
  import sftc_pkg::*;
  localparam logic [11:0] CTRL = {SFTC_IDX_TX_CTRL, 2'b00};
  localparam logic [11:0] STAT = {SFTC_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] MASK = {SFTC_IDX_IRQ_MASK, 2'b00};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go, ld;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i, tx_fifo_count_i, tx_fifo_threshold_i, ld_val;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] tx_fifo_data_i, shift_byte_o, b;
  logic tx_fifo_pop_o, shift_busy_i, shift_start_i, sdo_i, sdo_o;
  logic transfer_complete_flag_i, tx_fifo_request_o, tx_held_o;
  logic serial_irq_o, irq_o;
  int miscompares, check_count, cycles;
  sftc_ctrl #(.CNT_W(4)) DUT (.*);
  sftc_peer u_peer (.clk_i, .rst_i, .go_i(go), .ld_i(ld), .ld_val_i(ld_val),
    .pop_i(tx_fifo_pop_o), .count_o(tx_fifo_count_i),
    .head_o(tx_fifo_data_i), .start_o(shift_start_i),
    .busy_o(shift_busy_i), .sdo_o(sdo_i), .done_o(transfer_complete_flag_i));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Hang guard: whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // Classic single cycle; holds everything until ack is sampled
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // Only the hang guard ends this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic xfer;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    repeat (2) @(posedge clk_i);
    b = shift_byte_o;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (shift_busy_i !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_regs;
    bus(0, CTRL, 0); chk(32'hd0, rd);
    bus(1, CTRL, 32'hff); bus(0, CTRL, 0); chk(32'hf0, rd);
    bus(1, CTRL, 32'hd0);
    bus(1, 12'h000, 32'hff); bus(0, 12'h000, 0); chk(0, rd);
    $display("test regs done");
  endtask
  task automatic t_req;
    ld_val <= 4'h5;
    ld <= 1;
    @(posedge clk_i);
    ld <= 0;
    repeat (2) @(posedge clk_i);
    chk(0, tx_fifo_request_o);
    bus(0, CTRL, 0); chk(32'h50, rd);
    tx_fifo_threshold_i <= 4'h5;
    repeat (2) @(posedge clk_i);
    chk(1, tx_fifo_request_o);
    $display("test request done");
  endtask
  task automatic t_irq;
    bus(1, CTRL, 32'h40);
    bus(0, STAT, 0);
    chk(2, rd);
    xfer();
    idle();
    chk(0, serial_irq_o);
    chk(0, irq_o);
    // Interrupt outputs are registered: one more edge after the write
    bus(1, MASK, 32'h1);
    @(posedge clk_i);
    chk(1, irq_o);
    bus(1, CTRL, 32'h50);
    @(posedge clk_i);
    chk(1, serial_irq_o);
    bus(0, STAT, 0); chk(1, rd);
    @(posedge clk_i);
    chk(0, irq_o);
    $display("test irq done");
  endtask
  task automatic t_hold;
    xfer(); chk(32'ha4, b);
    bus(1, CTRL, 32'h30); chk(0, tx_held_o);
    idle(); chk(1, tx_held_o);
    chk(0, sdo_o);
    xfer(); chk(32'hff, b);
    idle(); chk(3, tx_fifo_count_i);
    bus(1, CTRL, 32'h70);
    @(posedge clk_i);
    chk(1, sdo_o);
    bus(1, CTRL, 32'h50);
    xfer(); chk(32'ha3, b);
    idle(); chk(2, tx_fifo_count_i);
    $display("test hold done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rst_i = 1;
    {wb_cyc_i, wb_stb_i, wb_we_i, go, ld} = '0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'hf;
    ld_val = '0;
    tx_fifo_threshold_i = 4'h4;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs();
    t_req();
    t_irq();
    t_hold();
    stop_test();
  end
endmodule
bind sftc_ctrl sftc_ctrl_chk #(.CNT_W(CNT_W)) u_chk (.*);

//--- test/sftc_peer.sv
// Shift engine and transmit FIFO model facing the control block
`timescale 1ns/1ps
module sftc_peer (
  input wire logic clk_i,          // Clock
  input wire logic rst_i,          // Reset
  input wire logic go_i,           // Begin transfer
  input wire logic ld_i,           // Load fill
  input wire logic [3:0] ld_val_i, // Fill to load
  input wire logic pop_i,          // Pop
  output logic [3:0] count_o,      // Fill
  output logic [7:0] head_o,       // Head byte
  output logic start_o,            // Start pulse
  output logic busy_o,             // Shifting
  output logic sdo_o,              // Engine data
  output logic done_o              // Done flag
);
  logic [3:0] bit_q;
  // Head differs per entry so a wrong pop shows
  assign head_o = {4'ha, count_o};
  assign busy_o = bit_q != 4'h0;
  // Toggles every cycle so a stale level is never mistaken
  always_ff @(posedge clk_i) sdo_o <= rst_i ? 1'b0 : !sdo_o;
  // Fill level, loaded by the bench, drained by pops
  always_ff @(posedge clk_i) begin
    if (rst_i)
      count_o <= 4'h0;
    else if (ld_i)
      count_o <= ld_val_i;
    else if (pop_i)
      count_o <= count_o - 4'h1;
  end
  // Eight bit times a byte, flag raised at the end
  always_ff @(posedge clk_i) begin
    start_o <= go_i && !rst_i;
    if (rst_i || go_i)
      done_o <= 1'b0;
    else if (bit_q == 4'h1)
      done_o <= 1'b1;
    if (rst_i)
      bit_q <= 4'h0;
    else if (go_i)
      bit_q <= 4'h8;
    else if (bit_q != 4'h0)
      bit_q <= bit_q - 4'h1;
  end
endmodule
